// ### src/fcm_consts.svh
// flow-control message port: widths, sizes and reset values
// assumes inclusion by bare name ahead of the package and modules
`ifndef FCM_CONSTS_SVH
`define FCM_CONSTS_SVH

// byte lanes of the shared transmit data word
`define FCM_TX_BYTES 4
`define FCM_TX_W 32
// byte lanes of the received-message stream
`define FCM_RX_BYTES 16
`define FCM_RX_W 128
// message size code and pause count widths
`define FCM_SIZE_W 3
`define FCM_PAUSE_W 4
// link-side argument field (size code or pause count)
`define FCM_ARG_W 4
// byte counter width, holds 0..16
`define FCM_CNT_W 5
// reset values
`define FCM_RST_BYTE 5'h00
`define FCM_RST_WORD 32'h0000_0000
`define FCM_RST_MSG 128'h0

`endif

// ### src/fcm_pkg.sv
// flow-control message port: shared types and size arithmetic
// assumes fcm_consts.svh is on the include path
`include "fcm_consts.svh"

package fcm_pkg;

  // core configuration direction
  typedef enum logic [1:0] {FCM_DIR_FULL, FCM_DIR_TX, FCM_DIR_RX} fcm_dir_t;

  // kind of word carried over the link
  typedef enum logic [2:0] {
    FCM_K_IDLE,
    FCM_K_DATA,
    FCM_K_UFC_HDR,
    FCM_K_UFC_DATA,
    FCM_K_NFC
  } fcm_kind_t;

  // payload bytes selected by a size code: two times code plus two
  function automatic logic [`FCM_CNT_W-1:0] fcm_msg_bytes(
    input logic [`FCM_SIZE_W-1:0] code
  );
    fcm_msg_bytes = {1'b0, code, 1'b0} + 5'h02;
  endfunction : fcm_msg_bytes

  // data-port words needed to carry a message of the given code
  function automatic logic [2:0] fcm_msg_words(
    input logic [`FCM_SIZE_W-1:0] code
  );
    logic [`FCM_CNT_W-1:0] b;
    b = fcm_msg_bytes(code) + 5'h03;
    fcm_msg_words = b[4:2];
  endfunction : fcm_msg_words

  // contiguous low-byte mask for a byte count 0..16
  function automatic logic [`FCM_RX_BYTES-1:0] fcm_byte_mask(
    input logic [`FCM_CNT_W-1:0] n
  );
    fcm_byte_mask = '0;
    for (int i = 0; i < `FCM_RX_BYTES; i++)
    begin
      fcm_byte_mask[i] = (5'(i) < n);
    end
  endfunction : fcm_byte_mask

endpackage : fcm_pkg

// ### src/fcm_if.sv
// flow-control message port: signals between core end and user end
// assumes both ends run on one shared clock
`timescale 1ns/100ps
`default_nettype none
`include "fcm_consts.svh"

interface fcm_if;
  // shared transmit data port
  logic [`FCM_TX_W-1:0] txData;
  logic txValid;
  logic txReady;
  // user message send request and grant
  logic ufcTxReq;
  logic [`FCM_SIZE_W-1:0] user_msg_size_code;
  logic ufcTxAck;
  // received user message stream
  logic [`FCM_RX_W-1:0] msgRxData;
  logic msgRxValid;
  logic msgRxLast;
  logic [`FCM_RX_BYTES-1:0] msgRxKeep;
  // pause message send request and grant
  logic nfcReq;
  logic [`FCM_PAUSE_W-1:0] pause_msg_count_out;
  logic nfcAck;
  // received pause message
  logic pauseRxStrobe;
  logic [`FCM_PAUSE_W-1:0] pause_msg_rx_count;

  modport core (
    input txData, txValid, ufcTxReq, user_msg_size_code, nfcReq,
    input pause_msg_count_out,
    output txReady, ufcTxAck, msgRxData, msgRxValid, msgRxLast,
    output msgRxKeep, nfcAck, pauseRxStrobe, pause_msg_rx_count
  );

  modport user (
    output txData, txValid, ufcTxReq, user_msg_size_code, nfcReq,
    output pause_msg_count_out,
    input txReady, ufcTxAck, msgRxData, msgRxValid, msgRxLast,
    input msgRxKeep, nfcAck, pauseRxStrobe, pause_msg_rx_count
  );
endinterface : fcm_if

`default_nettype wire

// ### src/fcm_core_end.sv
// flow-control message port, core end: grants and frames user messages
// and pause messages onto the link, and unpacks them from the link.
// assumes one clock, link takes one word per cycle, user end obeys grants.
//
// Operation
// R1: message ports exist only with option enabled
// R2: simplex keeps only its own direction ports
// R3: user holds send request until grant
// R4: request only once whole message ready
// R5: started message finishes without other traffic
// R6: user presents 3-bit size code with request
// R7: code selects two times code plus two bytes
// R8: grant asserted when ready for message contents
// R9: data words after grant are message payload
// R10: drop normal accept right after grant
// R11: consume payload words for encoded size, then resume
// R12: bytes beyond message length are dropped
// R13: word taken only when accept and valid high
// R14: received message delivered on 16-byte stream
// R15: receive outputs meaningful only while valid high
// R16: end flag on final received word
// R17: byte qualifier gives valid bytes on last word
// R18: pause interface only in full duplex
// R19: user holds pause request until grant
// R20: user holds 4-bit pause count until grant
// R21: pause grant asserted when request accepted
// R22: pause-received strobe lasts one cycle
// R23: received pause count sampled with strobe
`timescale 1ns/100ps
`default_nettype none
`include "fcm_consts.svh"

module fcm_core_end #(
  parameter bit HAS_UFC = 1'b1, // user messages built in
  parameter bit HAS_NFC = 1'b1, // pause messages built in
  parameter fcm_pkg::fcm_dir_t LINK_DIR = fcm_pkg::FCM_DIR_FULL // direction
) (
  input wire logic sys_clk, // core clock
  input wire logic resetn, // async reset, low
  fcm_if.core fc, // toward user logic
  output fcm_pkg::fcm_kind_t linkTxKind, // kind of outgoing word
  output logic [`FCM_TX_W-1:0] linkTxWord, // outgoing word
  output logic [`FCM_TX_BYTES-1:0] linkTxKeep, // valid outgoing bytes
  output logic [`FCM_ARG_W-1:0] linkTxArg, // size code or pause count
  input wire logic linkRxValid, // incoming word present
  input wire fcm_pkg::fcm_kind_t linkRxKind, // kind of incoming word
  input wire logic [`FCM_TX_W-1:0] linkRxWord, // incoming word
  input wire logic [`FCM_ARG_W-1:0] linkRxArg // incoming size or count
);
  import fcm_pkg::*;

  // option gating per direction
  localparam bit TX_ON = (LINK_DIR != FCM_DIR_RX); // R2
  localparam bit TX_UFC = HAS_UFC && TX_ON; // R1 R2
  localparam bit RX_UFC = HAS_UFC && (LINK_DIR != FCM_DIR_TX); // R1 R2
  localparam bit NFC_ON = HAS_NFC && (LINK_DIR == FCM_DIR_FULL); // R18

  typedef enum logic {FCM_TX_IDLE, FCM_TX_PAYLOAD} fcm_tx_st_t;

  fcm_tx_st_t txSt_r, txSt_nxt;
  logic [`FCM_CNT_W-1:0] txRem_r, txRem_nxt;
  logic [`FCM_SIZE_W-1:0] sizeHold_r, sizeHold_nxt;
  logic [`FCM_PAUSE_W-1:0] pauseHold_r, pauseHold_nxt;
  logic txReady_r, txReady_nxt;
  logic ufcAck_r, ufcAck_nxt;
  logic nfcAck_r, nfcAck_nxt;
  fcm_kind_t linkKind_r, linkKind_nxt;
  logic [`FCM_TX_W-1:0] linkWord_r, linkWord_nxt;
  logic [`FCM_TX_BYTES-1:0] linkKeep_r, linkKeep_nxt;
  logic [`FCM_ARG_W-1:0] linkArg_r, linkArg_nxt;
  logic accept, goNfc, goUfc;
  logic [`FCM_RX_BYTES-1:0] txMask;

  // word handshake and grant decisions
  assign accept = txReady_r && fc.txValid; // R13
  assign goNfc = NFC_ON && (txSt_r == FCM_TX_IDLE) && fc.nfcReq
    && !nfcAck_r; // R21
  assign goUfc = TX_UFC && (txSt_r == FCM_TX_IDLE) && !goNfc
    && fc.ufcTxReq && !ufcAck_r; // R8
  assign txMask = fcm_byte_mask(txRem_r);

  // transmit sequencing next values
  always_comb
  begin
    txSt_nxt = txSt_r;
    txRem_nxt = txRem_r;
    sizeHold_nxt = sizeHold_r;
    pauseHold_nxt = pauseHold_r;
    txReady_nxt = txReady_r;
    ufcAck_nxt = 1'b0;
    nfcAck_nxt = 1'b0;
    linkKind_nxt = FCM_K_IDLE;
    linkWord_nxt = linkWord_r;
    linkKeep_nxt = '0;
    linkArg_nxt = '0;
    unique case (txSt_r)
      FCM_TX_IDLE:
      begin
        if (accept)
        begin
          linkKind_nxt = FCM_K_DATA;
          linkWord_nxt = fc.txData;
          linkKeep_nxt = '1;
        end
        if (goNfc)
        begin
          nfcAck_nxt = 1'b1;
          pauseHold_nxt = fc.pause_msg_count_out; // R20
        end
        else if (goUfc)
        begin
          ufcAck_nxt = 1'b1;
          sizeHold_nxt = fc.user_msg_size_code; // R6
          txRem_nxt = fcm_msg_bytes(fc.user_msg_size_code); // R7
          txSt_nxt = FCM_TX_PAYLOAD; // R9
        end
        txReady_nxt = TX_ON && !(goNfc || goUfc); // R10
      end
      FCM_TX_PAYLOAD:
      begin
        // only payload words leave while a message is open
        txReady_nxt = 1'b1; // R5
        if (accept)
        begin
          linkKind_nxt = FCM_K_UFC_DATA; // R9
          linkWord_nxt = fc.txData;
          linkKeep_nxt = txMask[`FCM_TX_BYTES-1:0]; // R12
          if (txRem_r <= 5'h04)
          begin
            txRem_nxt = 5'h00;
            txSt_nxt = FCM_TX_IDLE; // R11
          end
          else
          begin
            txRem_nxt = txRem_r - 5'h04; // R11
          end
        end
      end
    endcase
    // message headers follow their grant by one cycle
    if (nfcAck_r)
    begin
      linkKind_nxt = FCM_K_NFC;
      linkArg_nxt = pauseHold_r;
    end
    else if (ufcAck_r)
    begin
      linkKind_nxt = FCM_K_UFC_HDR;
      linkArg_nxt = {1'b0, sizeHold_r};
    end
  end

  // transmit sequencing registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txSt_r <= FCM_TX_IDLE;
      txRem_r <= `FCM_RST_BYTE;
      sizeHold_r <= '0;
      pauseHold_r <= '0;
      txReady_r <= 1'b0;
      ufcAck_r <= 1'b0;
      nfcAck_r <= 1'b0;
      linkKind_r <= FCM_K_IDLE;
      linkWord_r <= `FCM_RST_WORD;
      linkKeep_r <= '0;
      linkArg_r <= '0;
    end
    else
    begin
      txSt_r <= txSt_nxt;
      txRem_r <= txRem_nxt;
      sizeHold_r <= sizeHold_nxt;
      pauseHold_r <= pauseHold_nxt;
      txReady_r <= txReady_nxt;
      ufcAck_r <= ufcAck_nxt;
      nfcAck_r <= nfcAck_nxt;
      linkKind_r <= linkKind_nxt;
      linkWord_r <= linkWord_nxt;
      linkKeep_r <= linkKeep_nxt;
      linkArg_r <= linkArg_nxt;
    end
  end

  logic [`FCM_CNT_W-1:0] rxRem_r, rxRem_nxt;
  logic [`FCM_CNT_W-1:0] rxFill_r, rxFill_nxt;
  logic [`FCM_RX_W-1:0] rxBuf_r, rxBuf_nxt;
  logic [`FCM_RX_W-1:0] msgData_r, msgData_nxt;
  logic [`FCM_RX_BYTES-1:0] msgKeep_r, msgKeep_nxt;
  logic msgValid_r, msgValid_nxt;
  logic pauseStb_r, pauseStb_nxt;
  logic [`FCM_PAUSE_W-1:0] pauseCnt_r, pauseCnt_nxt;

  // receive unpacking next values
  always_comb
  begin
    logic [`FCM_CNT_W-1:0] pos;
    logic [`FCM_CNT_W-1:0] take;
    pos = '0;
    take = '0;
    rxRem_nxt = rxRem_r;
    rxFill_nxt = rxFill_r;
    rxBuf_nxt = rxBuf_r;
    msgData_nxt = msgData_r;
    msgKeep_nxt = msgKeep_r;
    msgValid_nxt = 1'b0;
    pauseStb_nxt = 1'b0; // R22
    pauseCnt_nxt = pauseCnt_r;
    if (linkRxValid)
    begin
      unique case (linkRxKind)
        FCM_K_UFC_HDR:
        begin
          if (RX_UFC)
          begin
            rxRem_nxt = fcm_msg_bytes(linkRxArg[`FCM_SIZE_W-1:0]); // R7
            rxFill_nxt = '0;
            rxBuf_nxt = `FCM_RST_MSG;
          end
        end
        FCM_K_UFC_DATA:
        begin
          if (RX_UFC && rxRem_r != 5'h00)
          begin
            take = (rxRem_r > 5'h04) ? 5'h04 : rxRem_r;
            for (int i = 0; i < `FCM_TX_BYTES; i++)
            begin
              pos = rxFill_r + 5'(i);
              if (5'(i) < take)
              begin
                rxBuf_nxt[8*pos +: 8] = linkRxWord[8*i +: 8];
              end
            end
            rxFill_nxt = rxFill_r + take;
            rxRem_nxt = rxRem_r - take;
            if (rxRem_nxt == 5'h00)
            begin
              msgValid_nxt = 1'b1; // R16
              msgData_nxt = rxBuf_nxt; // R14
              msgKeep_nxt = fcm_byte_mask(rxFill_nxt); // R17
            end
          end
        end
        FCM_K_NFC:
        begin
          if (NFC_ON)
          begin
            pauseStb_nxt = 1'b1; // R22
            pauseCnt_nxt = linkRxArg; // R23
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // receive unpacking registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxRem_r <= `FCM_RST_BYTE;
      rxFill_r <= `FCM_RST_BYTE;
      rxBuf_r <= `FCM_RST_MSG;
      msgData_r <= `FCM_RST_MSG;
      msgKeep_r <= '0;
      msgValid_r <= 1'b0;
      pauseStb_r <= 1'b0;
      pauseCnt_r <= '0;
    end
    else
    begin
      rxRem_r <= rxRem_nxt;
      rxFill_r <= rxFill_nxt;
      rxBuf_r <= rxBuf_nxt;
      msgData_r <= msgData_nxt;
      msgKeep_r <= msgKeep_nxt;
      msgValid_r <= msgValid_nxt;
      pauseStb_r <= pauseStb_nxt;
      pauseCnt_r <= pauseCnt_nxt;
    end
  end

  // outputs straight from registers
  assign fc.txReady = txReady_r; // R13
  assign fc.ufcTxAck = ufcAck_r; // R8
  assign fc.nfcAck = nfcAck_r; // R21
  assign fc.msgRxData = msgData_r;
  assign fc.msgRxValid = msgValid_r; // R15
  assign fc.msgRxLast = msgValid_r; // R16
  assign fc.msgRxKeep = msgKeep_r; // R17
  assign fc.pauseRxStrobe = pauseStb_r;
  assign fc.pause_msg_rx_count = pauseCnt_r; // R23
  assign linkTxKind = linkKind_r;
  assign linkTxWord = linkWord_r;
  assign linkTxKeep = linkKeep_r;
  assign linkTxArg = linkArg_r;

endmodule : fcm_core_end

`default_nettype wire

// ### src/fcm_user_end.sv
// flow-control message port, user end: requests and feeds messages,
// and catches received messages and pause requests.
// assumes the core end on the same clock across fcm_if.
`timescale 1ns/100ps
`default_nettype none
`include "fcm_consts.svh"

module fcm_user_end (
  input wire logic sys_clk, // core clock
  input wire logic resetn, // async reset, low
  fcm_if.user fc, // toward the core
  input wire logic msgSend, // pulse: send a user message
  input wire logic [`FCM_SIZE_W-1:0] msgSize, // size code for msgSend
  input wire logic [`FCM_RX_W-1:0] msgBody, // message bytes, byte 0 low
  output logic msgBusy, // message in progress
  input wire logic pauseSend, // pulse: send a pause request
  input wire logic [`FCM_PAUSE_W-1:0] pauseCount, // idles to ask for
  output logic pauseBusy, // pause request pending
  output logic [`FCM_RX_W-1:0] rxMsgData, // last received message
  output logic [`FCM_RX_BYTES-1:0] rxMsgKeep, // its valid bytes
  output logic rxMsgValid, // pulse: message received
  output logic pauseSeen, // pulse: pause request received
  output logic [`FCM_PAUSE_W-1:0] pauseSeenCount // its pause count
);
  import fcm_pkg::*;

  typedef enum logic [1:0] {FCM_U_IDLE, FCM_U_REQ, FCM_U_SEND} fcm_u_st_t;

  fcm_u_st_t st_r, st_nxt;
  logic [`FCM_RX_W-1:0] body_r, body_nxt;
  logic [`FCM_SIZE_W-1:0] size_r, size_nxt;
  logic [2:0] word_r, word_nxt;
  logic req_r, req_nxt;
  logic txValid_r, txValid_nxt;
  logic [`FCM_TX_W-1:0] txData_r, txData_nxt;
  logic nfcReq_r, nfcReq_nxt;
  logic [`FCM_PAUSE_W-1:0] nfcCnt_r, nfcCnt_nxt;

  // message and pause request next values
  always_comb
  begin
    st_nxt = st_r;
    body_nxt = body_r;
    size_nxt = size_r;
    word_nxt = word_r;
    req_nxt = req_r;
    txValid_nxt = txValid_r;
    txData_nxt = txData_r;
    nfcReq_nxt = nfcReq_r;
    nfcCnt_nxt = nfcCnt_r;
    unique case (st_r)
      FCM_U_IDLE:
      begin
        if (msgSend)
        begin
          // whole message captured before requesting
          body_nxt = msgBody; // R4
          size_nxt = msgSize; // R6
          req_nxt = 1'b1;
          st_nxt = FCM_U_REQ;
        end
      end
      FCM_U_REQ:
      begin
        if (fc.ufcTxAck)
        begin
          req_nxt = 1'b0; // R3
          word_nxt = 3'h0;
          txValid_nxt = 1'b1;
          txData_nxt = body_r[`FCM_TX_W-1:0]; // R9
          st_nxt = FCM_U_SEND;
        end
      end
      FCM_U_SEND:
      begin
        if (fc.txReady && txValid_r)
        begin
          word_nxt = word_r + 3'h1; // R13
          if (word_nxt == fcm_msg_words(size_r))
          begin
            txValid_nxt = 1'b0; // R11
            st_nxt = FCM_U_IDLE;
          end
          else
          begin
            txData_nxt = body_r[`FCM_TX_W*word_nxt +: `FCM_TX_W];
          end
        end
      end
      default:
      begin
        st_nxt = FCM_U_IDLE;
      end
    endcase
    // pause request held with its count until granted
    if (nfcReq_r && fc.nfcAck)
    begin
      nfcReq_nxt = 1'b0; // R19
    end
    else if (!nfcReq_r && pauseSend)
    begin
      nfcReq_nxt = 1'b1;
      nfcCnt_nxt = pauseCount; // R20
    end
  end

  // request registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= FCM_U_IDLE;
      body_r <= `FCM_RST_MSG;
      size_r <= '0;
      word_r <= 3'h0;
      req_r <= 1'b0;
      txValid_r <= 1'b0;
      txData_r <= `FCM_RST_WORD;
      nfcReq_r <= 1'b0;
      nfcCnt_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      body_r <= body_nxt;
      size_r <= size_nxt;
      word_r <= word_nxt;
      req_r <= req_nxt;
      txValid_r <= txValid_nxt;
      txData_r <= txData_nxt;
      nfcReq_r <= nfcReq_nxt;
      nfcCnt_r <= nfcCnt_nxt;
    end
  end

  logic [`FCM_RX_W-1:0] rxData_r, rxData_nxt;
  logic [`FCM_RX_BYTES-1:0] rxKeep_r, rxKeep_nxt;
  logic rxValid_r, rxValid_nxt;
  logic seen_r, seen_nxt;
  logic [`FCM_PAUSE_W-1:0] seenCnt_r, seenCnt_nxt;

  // receive capture next values
  always_comb
  begin
    rxValid_nxt = fc.msgRxValid && fc.msgRxLast; // R15
    rxData_nxt = rxValid_nxt ? fc.msgRxData : rxData_r;
    rxKeep_nxt = rxValid_nxt ? fc.msgRxKeep : rxKeep_r; // R17
    seen_nxt = fc.pauseRxStrobe;
    seenCnt_nxt = fc.pauseRxStrobe ? fc.pause_msg_rx_count : seenCnt_r; // R23
  end

  // receive capture registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxData_r <= `FCM_RST_MSG;
      rxKeep_r <= '0;
      rxValid_r <= 1'b0;
      seen_r <= 1'b0;
      seenCnt_r <= '0;
    end
    else
    begin
      rxData_r <= rxData_nxt;
      rxKeep_r <= rxKeep_nxt;
      rxValid_r <= rxValid_nxt;
      seen_r <= seen_nxt;
      seenCnt_r <= seenCnt_nxt;
    end
  end

  // interface and user outputs from registers
  assign fc.txData = txData_r;
  assign fc.txValid = txValid_r;
  assign fc.ufcTxReq = req_r; // R3
  assign fc.user_msg_size_code = size_r; // R6
  assign fc.nfcReq = nfcReq_r; // R19
  assign fc.pause_msg_count_out = nfcCnt_r; // R20
  assign msgBusy = (st_r != FCM_U_IDLE);
  assign pauseBusy = nfcReq_r;
  assign rxMsgData = rxData_r;
  assign rxMsgKeep = rxKeep_r;
  assign rxMsgValid = rxValid_r;
  assign pauseSeen = seen_r;
  assign pauseSeenCount = seenCnt_r;

endmodule : fcm_user_end

`default_nettype wire

// ### bench/fcm_assertions.sv
// flow-control message port: handshake and frame checker
// assumes one clock shared by both ends of fcm_if
`timescale 1ns/100ps
`default_nettype none
`include "fcm_consts.svh"

module fcm_assertions (
  input wire logic sys_clk, // core clock
  input wire logic resetn, // async reset, low
  input wire logic txValid, // payload valid
  input wire logic txReady, // core accepts word
  input wire logic ufcTxReq, // message request
  input wire logic [`FCM_SIZE_W-1:0] user_msg_size_code, // size code
  input wire logic ufcTxAck, // message grant
  input wire logic msgRxValid, // received message valid
  input wire logic msgRxLast, // received message end
  input wire logic [`FCM_RX_BYTES-1:0] msgRxKeep, // received byte mask
  input wire logic nfcReq, // pause request
  input wire logic [`FCM_PAUSE_W-1:0] pause_msg_count_out, // pause count
  input wire logic nfcAck, // pause grant
  input wire logic pauseRxStrobe, // pause received
  input wire logic [`FCM_PAUSE_W-1:0] pause_msg_rx_count // received count
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // requests hold with their arguments until granted
  a_req_held: assert property (ufcTxReq && !ufcTxAck |=> ufcTxReq)
    else $error("message request dropped early");
  a_size_stable: assert property (ufcTxReq && !ufcTxAck |=>
    $stable(user_msg_size_code)) else $error("size code moved");
  a_pause_held: assert property (nfcReq && !nfcAck |=>
    nfcReq && $stable(pause_msg_count_out)) else $error("pause req moved");
  // grants answer a request and last one cycle
  a_grant_pulse: assert property (ufcTxAck |-> $past(ufcTxReq)
    ##1 !ufcTxAck) else $error("bad message grant");
  a_nfc_grant: assert property (nfcAck |-> $past(nfcReq) ##1 !nfcAck)
    else $error("bad pause grant");
  a_grant_excl: assert property (!(ufcTxAck && nfcAck))
    else $error("two grants at once");
  // accept drops at grant, payload follows at once
  a_ready_drop: assert property (ufcTxAck |-> !txReady)
    else $error("accept high during grant");
  a_payload_go: assert property (ufcTxAck |=> txValid && txReady)
    else $error("payload not started");
  // received frames are one beat with contiguous low bytes
  a_rx_frame: assert property (msgRxValid |-> msgRxLast &&
    msgRxKeep[1:0] == 2'h3 && ((msgRxKeep + 16'h1) & msgRxKeep) == 16'h0)
    else $error("bad received frame");
  a_last_valid: assert property (msgRxLast |-> msgRxValid)
    else $error("end flag without valid");
  a_strobe_one: assert property (pauseRxStrobe |=> !pauseRxStrobe
    && $stable(pause_msg_rx_count)) else $error("pause strobe too long");
endmodule : fcm_assertions

`default_nettype wire

// ### bench/flow_control_msg_port_tb_top.sv
// flow-control message port: loopback bench with queue model
// assumes the core link output is looped back into its own link input
`timescale 1ns/100ps
`default_nettype none
`include "fcm_consts.svh"

module flow_control_msg_port_tb_top;
  import fcm_pkg::*;
  typedef struct packed {logic [2:0] code; logic [127:0] body;} fcm_msg_t;
  logic sys_clk = 1'b0;
  logic resetn;
  logic msgSend, pauseSend, msgBusy, pauseBusy, rxMsgValid, pauseSeen;
  logic [2:0] msgSize;
  logic [127:0] msgBody, rxMsgData;
  logic [15:0] rxMsgKeep;
  logic [3:0] pauseCount, pauseSeenCount, linkTxArg;
  logic [3:0] linkRxArg = 4'h0;
  logic [3:0] linkTxKeep;
  logic [31:0] linkTxWord;
  logic [31:0] linkRxWord = 32'h0;
  logic linkRxValid = 1'b0;
  fcm_kind_t linkTxKind;
  fcm_kind_t linkRxKind = FCM_K_IDLE;
  fcm_msg_t txQ[$], rxQ[$], cur, got;
  logic [3:0] pauseQ[$];
  int errorCnt = 0, samplesChecked = 0, cycles = 0;
  int wordsLeft = 0, wordIdx = 0, k;

  fcm_if fcIf ();
  fcm_core_end fcm_core_end_inst (.sys_clk(sys_clk), .resetn(resetn),
    .fc(fcIf.core), .linkTxKind(linkTxKind), .linkTxWord(linkTxWord),
    .linkTxKeep(linkTxKeep), .linkTxArg(linkTxArg),
    .linkRxValid(linkRxValid), .linkRxKind(linkRxKind),
    .linkRxWord(linkRxWord), .linkRxArg(linkRxArg));
  fcm_user_end fcm_user_end_inst (.sys_clk(sys_clk), .resetn(resetn),
    .fc(fcIf.user), .msgSend(msgSend), .msgSize(msgSize),
    .msgBody(msgBody), .msgBusy(msgBusy), .pauseSend(pauseSend),
    .pauseCount(pauseCount), .pauseBusy(pauseBusy),
    .rxMsgData(rxMsgData), .rxMsgKeep(rxMsgKeep), .rxMsgValid(rxMsgValid),
    .pauseSeen(pauseSeen), .pauseSeenCount(pauseSeenCount));
  fcm_assertions fcm_assertions_inst (.sys_clk(sys_clk), .resetn(resetn),
    .txValid(fcIf.txValid), .txReady(fcIf.txReady),
    .ufcTxReq(fcIf.ufcTxReq), .user_msg_size_code(fcIf.user_msg_size_code),
    .ufcTxAck(fcIf.ufcTxAck), .msgRxValid(fcIf.msgRxValid),
    .msgRxLast(fcIf.msgRxLast), .msgRxKeep(fcIf.msgRxKeep),
    .nfcReq(fcIf.nfcReq), .pause_msg_count_out(fcIf.pause_msg_count_out),
    .nfcAck(fcIf.nfcAck), .pauseRxStrobe(fcIf.pauseRxStrobe),
    .pause_msg_rx_count(fcIf.pause_msg_rx_count));
  // receive-only core on the same link, shadowing the user requests
  fcm_if fcIf2 ();
  fcm_kind_t rxOnlyKind;
  assign fcIf2.txData = fcIf.txData;
  assign fcIf2.txValid = fcIf.txValid;
  assign fcIf2.ufcTxReq = fcIf.ufcTxReq;
  assign fcIf2.user_msg_size_code = fcIf.user_msg_size_code;
  assign fcIf2.nfcReq = fcIf.nfcReq;
  assign fcIf2.pause_msg_count_out = fcIf.pause_msg_count_out;
  fcm_core_end #(.LINK_DIR(FCM_DIR_RX)) fcm_core_end_rx_inst (
    .sys_clk(sys_clk), .resetn(resetn), .fc(fcIf2.core),
    .linkTxKind(rxOnlyKind), .linkTxWord(), .linkTxKeep(), .linkTxArg(),
    .linkRxValid(linkRxValid), .linkRxKind(linkRxKind),
    .linkRxWord(linkRxWord), .linkRxArg(linkRxArg));

  // clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  // link loopback, one register stage
  always @(posedge sys_clk)
  begin
    linkRxValid <= (linkTxKind != FCM_K_IDLE);
    linkRxKind <= linkTxKind;
    linkRxWord <= linkTxWord;
    linkRxArg <= linkTxArg;
  end

  // byte mask for the low n bytes
  function automatic logic [127:0] laneMask(input int n);
    laneMask = '0;
    for (int i = 0; i < 16; i++)
    begin
      if (i < n) laneMask[8*i +: 8] = 8'hFF;
    end
  endfunction : laneMask

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic endOfTest;
    $display("errors=%0d checks=%0d", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : endOfTest

  // one request of either kind or both in the same cycle
  task automatic send(input bit doMsg, input logic [2:0] code,
    input bit doPause, input logic [3:0] cnt);
    fcm_msg_t m;
    do @(posedge sys_clk); while (msgBusy !== 1'b0 || pauseBusy !== 1'b0);
    m.code = code;
    m.body = {$urandom, $urandom, $urandom, $urandom};
    if (doMsg)
    begin
      txQ.push_back(m);
      rxQ.push_back(m);
    end
    if (doPause) pauseQ.push_back(cnt);
    msgSend <= doMsg;
    msgSize <= code;
    msgBody <= m.body;
    pauseSend <= doPause;
    pauseCount <= cnt;
    @(posedge sys_clk);
    msgSend <= 1'b0;
    pauseSend <= 1'b0;
  endtask : send

  // link words and delivered results against the model
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errorCnt++;
      endOfTest();
    end
    if (resetn === 1'b1 && linkTxKind === FCM_K_UFC_HDR)
    begin
      check(128'(wordsLeft), 128'h0);
      cur = txQ.pop_front();
      check(128'(linkTxArg), 128'(cur.code));
      wordsLeft = (2 * cur.code + 5) / 4;
      wordIdx = 0;
    end
    if (resetn === 1'b1 && linkTxKind === FCM_K_UFC_DATA)
    begin
      k = 2 * cur.code + 2 - 4 * wordIdx;
      k = (k > 4) ? 4 : k;
      check(128'(linkTxKeep), 128'((32'h1 << k) - 32'h1));
      check(128'(linkTxWord) & laneMask(k),
        128'(cur.body[32*wordIdx +: 32]) & laneMask(k));
      wordIdx++;
      wordsLeft--;
    end
    if (resetn === 1'b1 && rxMsgValid === 1'b1)
    begin
      got = rxQ.pop_front();
      k = 2 * got.code + 2;
      check(rxMsgData & laneMask(k), got.body & laneMask(k));
      check(128'(rxMsgKeep), 128'((17'h1 << k) - 17'h1));
      check(fcIf2.msgRxData & laneMask(k), got.body & laneMask(k));
    end
    // receive-only core never grants, accepts or reports pauses
    if (resetn === 1'b1)
      check(128'({fcIf2.txReady, fcIf2.ufcTxAck, fcIf2.nfcAck,
        fcIf2.pauseRxStrobe, rxOnlyKind}), 128'h0);
    if (resetn === 1'b1 && pauseSeen === 1'b1)
      check(128'(pauseSeenCount), 128'(pauseQ.pop_front()));
  end

  // main sequence
  initial
  begin
    resetn = 1'b0;
    msgSend = 1'b0;
    pauseSend = 1'b0;
    msgSize = 3'h0;
    msgBody = '0;
    pauseCount = 4'h0;
    void'($urandom(88936));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    // every size code, each message right behind the last
    for (int c = 0; c < 8; c++) send(1'b1, 3'(c), 1'b0, 4'h0);
    // boundary and random pause counts
    send(1'b0, 3'h0, 1'b1, 4'h0);
    send(1'b0, 3'h0, 1'b1, 4'hF);
    repeat (3) send(1'b0, 3'h0, 1'b1, 4'($urandom));
    // both requests in one cycle, pause first; then six messages alone
    repeat (4) send(1'b1, 3'($urandom), 1'b1, 4'($urandom));
    repeat (6) send(1'b1, 3'($urandom), 1'b0, 4'h0);
    repeat (60) @(posedge sys_clk);
    check(128'(rxQ.size() + pauseQ.size() + txQ.size()), 128'h0);
    check(128'(wordsLeft), 128'h0);
    endOfTest();
  end
endmodule : flow_control_msg_port_tb_top

`default_nettype wire
